// *** hw/cfl_pkg.sv ***
/*
  Shared constants for the configuration loader and fault-log guard:
  register offsets, field positions, command codes, status bits and phases.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package cfl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 8;
  localparam int LOG_W  = 16;
  localparam int NSTAT  = 6;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD      = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK     = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATE    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_INDEX    = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RAM      = 8'h18;
  localparam logic [ADDR_W-1:0] REG_FLASH    = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_LOG_SUM  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_LOG_DATA = 8'h24;

  // Control fields and reset value of write protection.
  localparam int   CTRL_WP     = 0;
  localparam int   CTRL_ATTACH = 1;
  localparam logic WP_RST      = 1'b1;

  // Command frame fields.
  localparam int         CMD_CODE_LSB = 0;
  localparam int         CMD_PEC_LSB  = 8;
  localparam int         CMD_LEN_LSB  = 16;
  localparam logic [1:0] LEN_NO_PEC   = 2'h1;
  localparam logic [1:0] LEN_PEC      = 2'h2;

  // Command codes.
  localparam logic [7:0] CMD_ROM   = 8'hd9;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_ERASE = 8'hf0;
  localparam logic [7:0] CMD_RESET = 8'hf1;
  localparam logic [7:0] PEC_POLY  = 8'h07;
  localparam logic [7:0] PEC_INIT  = 8'h00;

  // Status bits (sticky, write one to clear).
  localparam int ST_ROM     = 0;
  localparam int ST_PEC     = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_CORRUPT = 3;
  localparam int ST_STORE   = 4;
  localparam int ST_IMAGE   = 5;

  // Live state register fields.
  localparam int SV_ROM     = 0;
  localparam int SV_PEND    = 1;
  localparam int SV_BUSY    = 2;
  localparam int SV_WP      = 3;
  localparam int SV_ERASED  = 4;
  localparam int SV_CNT_LSB = 8;

  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {S_BOOT, S_CHECK, S_RUN, S_STORE, S_ERASE} cfl_phase_type;
endpackage : cfl_pkg

// *** hw/cfl_top.sv ***
/*
  Configuration loader and fault-log guard: working config memory, config
  flash with write protection, command decoder with optional PEC byte,
  and a checksummed fault log that is verified after every reset.
  Assumes an AXI4-Lite master on SYS_CLK and fault events from logic on the
  same clock. Flash, log and its count/checksum are not cleared by reset.
*/
// Notes on behaviour
// (RL1) A live update runs: clear write protection, erase flash, write the image, then reset.
// (RL2) After flash is rewritten the old config stays active and fault logging is off until reset.
// (RL3) Command D9h puts the device in ROM mode, doing nothing normal until a tool attaches.
// (RL4) Each command frame is accepted with or without a trailing PEC byte, told apart by its length.
// (RL5) The host should send PEC so a corrupted frame cannot pass as a valid command.
// (RL6) Every appended log entry updates the stored log checksum.
// (RL7) After each reset the log checksum is recomputed and a mismatch erases the whole log.
// (RL8) Host writes land in working memory and reach flash only through the store command; the code also writes image words at REG_FLASH straight to flash.
// (RL9) While write protection is on, every flash erase or write is refused and flash is unchanged.
`timescale 1ns/1ps
module cfl_top
  import cfl_pkg::*;
#(
  parameter int CFG_DEPTH = 16,
  parameter int LOG_DEPTH = 16
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic [cfl_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output wire logic                      S_AXI_AWREADY,
  input  wire logic [cfl_pkg::DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output wire logic                      S_AXI_WREADY,
  output wire logic [1:0]                S_AXI_BRESP,
  output wire logic                      S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [cfl_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output wire logic                      S_AXI_ARREADY,
  output wire logic [cfl_pkg::DATA_W-1:0] S_AXI_RDATA,
  output wire logic [1:0]                S_AXI_RRESP,
  output wire logic                      S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  input  wire logic                      FAULT_VALID,
  input  wire logic [cfl_pkg::LOG_W-1:0]  FAULT_CODE,
  output wire logic                      IRQ,
  output wire logic                      ROM_MODE,
  output wire logic                      LOG_SUPPRESS,
  output wire logic                      CFG_BUSY
);
  import cfl_pkg::*;

  localparam int CAW = $clog2(CFG_DEPTH);
  localparam int LAW = $clog2(LOG_DEPTH);

  typedef struct packed {
    cfl_phase_type     st;
    logic [CNT_W-1:0]  cnt;
    logic [LOG_W-1:0]  sum;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic              wp;
    logic              rom;
    logic              pend;
    logic              erased;
    logic [NSTAT-1:0]  status;
    logic [NSTAT-1:0]  mask;
    logic [CNT_W-1:0]  index;
  } cfl_regs_type;

  cfl_regs_type state_ff;
  cfl_regs_type nxt_state;

  // Memories; contents survive reset like the nonvolatile parts they stand for.
  logic [DATA_W-1:0] cfg_ram   [CFG_DEPTH];
  logic [DATA_W-1:0] cfg_flash [CFG_DEPTH];
  logic [LOG_W-1:0]  log_mem   [LOG_DEPTH];
  logic [CNT_W-1:0]  nv_cnt_ff = '0;
  logic [LOG_W-1:0]  nv_sum_ff = '0;

  logic              ram_we, fl_we, log_we, nv_clr, nv_sum_we;
  logic [CAW-1:0]    ram_wa, fl_wa;
  logic [DATA_W-1:0] ram_wd, fl_wd, wv;
  logic [LOG_W-1:0]  nv_sum_wd;
  logic [NSTAT-1:0]  set_b, clr_b;
  logic              cmd_take, cmd_ok, pec_ok;
  logic [7:0]        cmd_code;
  logic [1:0]        cmd_len;

  // CRC-8 over the command byte; a frame with a bad PEC must never act.
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = PEC_INIT ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  function automatic logic [DATA_W-1:0] strb_merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
                                                   input logic [3:0] s);
    logic [DATA_W-1:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction : strb_merge

  function automatic logic in_cfg(input logic [CNT_W-1:0] i);
    return i < CNT_W'(CFG_DEPTH);
  endfunction : in_cfg

  // Next-state logic: bus slave, command decoder, phase sequencer, log.
  always_comb begin
    nxt_state = state_ff;
    ram_we = 1'b0; ram_wa = '0; ram_wd = '0;
    fl_we = 1'b0; fl_wa = '0; fl_wd = '0;
    log_we = 1'b0; nv_clr = 1'b0; nv_sum_we = 1'b0; nv_sum_wd = '0;
    set_b = '0; clr_b = '0; cmd_take = 1'b0; cmd_ok = 1'b0;
    cmd_code = state_ff.wdata[CMD_CODE_LSB +: 8];
    cmd_len = state_ff.wdata[CMD_LEN_LSB +: 2];
    pec_ok = (cmd_len == LEN_NO_PEC) ||
             (cmd_len == LEN_PEC && state_ff.wdata[CMD_PEC_LSB +: 8] == crc8(cmd_code)); // [RL4]
    wv = '0;

    // Phase sequencer: boot copy, log check, store and erase walk one word a cycle.
    case (state_ff.st)
      S_BOOT: begin
        ram_we = 1'b1;
        ram_wa = state_ff.cnt[CAW-1:0];
        ram_wd = cfg_flash[state_ff.cnt[CAW-1:0]];
        nxt_state.cnt = state_ff.cnt + 1'b1;
        if (state_ff.cnt == CNT_W'(CFG_DEPTH - 1)) begin
          nxt_state.st = S_CHECK;
          nxt_state.cnt = '0;
          nxt_state.sum = '0;
        end
      end
      S_CHECK: begin
        if (state_ff.cnt >= nv_cnt_ff) begin
          if (state_ff.sum != nv_sum_ff) begin
            nv_clr = 1'b1;                                     // [RL7]
            set_b[ST_CORRUPT] = 1'b1;
          end
          nxt_state.st = S_RUN;
        end else begin
          nxt_state.sum = state_ff.sum + log_mem[state_ff.cnt[LAW-1:0]]; // [RL7]
          nxt_state.cnt = state_ff.cnt + 1'b1;
        end
      end
      S_STORE: begin
        fl_we = 1'b1;                                          // [RL8]
        fl_wa = state_ff.cnt[CAW-1:0];
        fl_wd = cfg_ram[state_ff.cnt[CAW-1:0]];
        nxt_state.cnt = state_ff.cnt + 1'b1;
        if (state_ff.cnt == CNT_W'(CFG_DEPTH - 1)) begin
          nxt_state.st = S_RUN;
          set_b[ST_STORE] = 1'b1;
        end
      end
      S_ERASE: begin
        fl_we = 1'b1;
        fl_wa = state_ff.cnt[CAW-1:0];
        fl_wd = ERASED_WORD;
        nxt_state.cnt = state_ff.cnt + 1'b1;
        if (state_ff.cnt == CNT_W'(CFG_DEPTH - 1)) begin
          nxt_state.st = S_RUN;
          nxt_state.erased = 1'b1;
        end
      end
      S_RUN: begin
        // A rewritten flash or ROM mode silences the log; a full log drops new faults.
        log_we = FAULT_VALID && !state_ff.pend && !state_ff.rom &&
                 nv_cnt_ff < CNT_W'(LOG_DEPTH);                // [RL2] [RL3] [RL6]
      end
      default: nxt_state.st = S_BOOT;
    endcase

    // Address and data channels are taken independently.
    if (S_AXI_AWVALID && !state_ff.aw_got && !state_ff.bvalid) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !state_ff.w_got && !state_ff.bvalid) begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = S_AXI_WDATA;
      nxt_state.wstrb = S_AXI_WSTRB;
    end
    if (state_ff.bvalid && S_AXI_BREADY) nxt_state.bvalid = 1'b0;
    if (state_ff.rvalid && S_AXI_RREADY) nxt_state.rvalid = 1'b0;

    // Register write, once both halves are held.
    if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = RESP_OKAY;
      case (state_ff.awaddr)
        REG_CTRL: begin
          wv = strb_merge({{(DATA_W-1){1'b0}}, state_ff.wp}, state_ff.wdata, state_ff.wstrb);
          nxt_state.wp = wv[CTRL_WP];
          if (wv[CTRL_ATTACH]) nxt_state.rom = 1'b0;           // [RL3]
        end
        REG_CMD: cmd_take = 1'b1;
        REG_STATUS: clr_b = state_ff.wdata[NSTAT-1:0] & {NSTAT{state_ff.wstrb[0]}};
        REG_MASK: begin
          wv = strb_merge({{(DATA_W-NSTAT){1'b0}}, state_ff.mask}, state_ff.wdata, state_ff.wstrb);
          nxt_state.mask = wv[NSTAT-1:0];
        end
        REG_INDEX: begin
          wv = strb_merge({{(DATA_W-CNT_W){1'b0}}, state_ff.index}, state_ff.wdata, state_ff.wstrb);
          nxt_state.index = wv[CNT_W-1:0];
        end
        REG_RAM: begin
          if (state_ff.st == S_RUN && !state_ff.rom && in_cfg(state_ff.index)) begin
            ram_we = 1'b1;                                     // [RL8]
            ram_wa = state_ff.index[CAW-1:0];
            ram_wd = strb_merge(cfg_ram[state_ff.index[CAW-1:0]], state_ff.wdata, state_ff.wstrb);
          end else begin
            nxt_state.bresp = RESP_SLVERR;
          end
        end
        REG_FLASH: begin
          // Image words go only into an erased, unprotected flash.
          if (state_ff.st == S_RUN && !state_ff.rom && !state_ff.wp &&
              state_ff.erased && in_cfg(state_ff.index)) begin   // [RL1] [RL9]
            fl_we = 1'b1;
            fl_wa = state_ff.index[CAW-1:0];
            fl_wd = state_ff.wdata;
            nxt_state.index = state_ff.index + 1'b1;
            nxt_state.pend = 1'b1;                              // [RL2]
            set_b[ST_IMAGE] = 1'b1;
          end else begin
            set_b[ST_REFUSED] = 1'b1;
            nxt_state.bresp = RESP_SLVERR;
          end
        end
        REG_LOG_SUM: begin
          nv_sum_we = 1'b1;
          nv_sum_wd = state_ff.wdata[LOG_W-1:0];
        end
        default: nxt_state.bresp = RESP_SLVERR;
      endcase
    end

    // Command frames act only while running.
    if (cmd_take) begin
      if (state_ff.st != S_RUN) begin
        nxt_state.bresp = RESP_SLVERR;
      end else if (!pec_ok) begin
        set_b[ST_PEC] = 1'b1;                                  // [RL4]
      end else begin
        cmd_ok = 1'b1;
      end
    end
    if (cmd_ok) begin
      case (cmd_code)
        CMD_ROM: begin
          nxt_state.rom = 1'b1;                                // [RL3]
          set_b[ST_ROM] = 1'b1;
        end
        CMD_STORE, CMD_ERASE: begin
          if (state_ff.rom || state_ff.wp) begin                // [RL9]
            set_b[ST_REFUSED] = 1'b1;
            nxt_state.bresp = RESP_SLVERR;
          end else begin
            nxt_state.st = (cmd_code == CMD_STORE) ? S_STORE : S_ERASE;
            nxt_state.cnt = '0;
            if (cmd_code == CMD_ERASE) nxt_state.pend = 1'b1;  // [RL2]
          end
        end
        CMD_RESET: begin
          if (state_ff.rom) begin
            nxt_state.bresp = RESP_SLVERR;
          end else begin
            // Soft reset restarts the boot copy with protection on but keeps status, mask and index; the new image loads now.
            nxt_state.st = S_BOOT;                             // [RL1]
            nxt_state.cnt = '0;
            nxt_state.pend = 1'b0;
            nxt_state.erased = 1'b0;
            nxt_state.wp = WP_RST;
          end
        end
        default: nxt_state.bresp = RESP_OKAY;
      endcase
    end

    // Read path, one answer outstanding at a time.
    if (S_AXI_ARVALID && !state_ff.rvalid) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = RESP_OKAY;
      nxt_state.rdata = '0;
      case (S_AXI_ARADDR)
        REG_CTRL: nxt_state.rdata[CTRL_WP] = state_ff.wp;
        REG_CMD: nxt_state.rdata = '0;
        REG_STATUS: nxt_state.rdata[NSTAT-1:0] = state_ff.status;
        REG_MASK: nxt_state.rdata[NSTAT-1:0] = state_ff.mask;
        REG_STATE: begin
          nxt_state.rdata[SV_ROM] = state_ff.rom;
          nxt_state.rdata[SV_PEND] = state_ff.pend;
          nxt_state.rdata[SV_BUSY] = state_ff.st != S_RUN;
          nxt_state.rdata[SV_WP] = state_ff.wp;
          nxt_state.rdata[SV_ERASED] = state_ff.erased;
          nxt_state.rdata[SV_CNT_LSB +: CNT_W] = nv_cnt_ff;
        end
        REG_INDEX: nxt_state.rdata[CNT_W-1:0] = state_ff.index;
        REG_RAM: if (in_cfg(state_ff.index)) nxt_state.rdata = cfg_ram[state_ff.index[CAW-1:0]];
        REG_FLASH: if (in_cfg(state_ff.index)) nxt_state.rdata = cfg_flash[state_ff.index[CAW-1:0]];
        REG_LOG_SUM: nxt_state.rdata[LOG_W-1:0] = nv_sum_ff;
        REG_LOG_DATA: begin
          if (state_ff.index < CNT_W'(LOG_DEPTH)) nxt_state.rdata[LOG_W-1:0] = log_mem[state_ff.index[LAW-1:0]];
        end
        default: nxt_state.rresp = RESP_SLVERR;
      endcase
    end

    // A new event wins over a clear in the same cycle.
    nxt_state.status = (state_ff.status & ~clr_b) | set_b;
  end

  // State register; reset starts the boot copy with protection on.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_ff <= '0;
      state_ff.st <= S_BOOT;
      state_ff.wp <= WP_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Memories and the stored log count and checksum.
  always_ff @(posedge SYS_CLK) begin
    if (ram_we) cfg_ram[ram_wa] <= ram_wd;
    if (fl_we) cfg_flash[fl_wa] <= fl_wd;
    if (log_we) log_mem[nv_cnt_ff[LAW-1:0]] <= FAULT_CODE;
    if (nv_clr) begin
      nv_cnt_ff <= '0;                                          // [RL7]
      nv_sum_ff <= '0;
    end else if (log_we) begin
      nv_cnt_ff <= nv_cnt_ff + 1'b1;
      nv_sum_ff <= nv_sum_ff + FAULT_CODE;                      // [RL6]
    end else if (nv_sum_we) begin
      nv_sum_ff <= nv_sum_wd;
    end
  end

  assign S_AXI_AWREADY = !state_ff.aw_got && !state_ff.bvalid;
  assign S_AXI_WREADY  = !state_ff.w_got && !state_ff.bvalid;
  assign S_AXI_BVALID  = state_ff.bvalid;
  assign S_AXI_BRESP   = state_ff.bresp;
  assign S_AXI_ARREADY = !state_ff.rvalid;
  assign S_AXI_RVALID  = state_ff.rvalid;
  assign S_AXI_RDATA   = state_ff.rdata;
  assign S_AXI_RRESP   = state_ff.rresp;
  assign IRQ           = |(state_ff.status & state_ff.mask);
  assign ROM_MODE      = state_ff.rom;
  assign LOG_SUPPRESS  = state_ff.pend || state_ff.rom;
  assign CFG_BUSY      = state_ff.st != S_RUN;

  // Checks on the behaviour above.
  property p_pend_quiet;
    @(posedge SYS_CLK) disable iff (SYS_RST) state_ff.pend |-> !log_we;
  endproperty
  a_pend_quiet: assert property (p_pend_quiet) else $error("log written while update pending"); // [RL2]
  property p_pend_hold;
    @(posedge SYS_CLK) disable iff (SYS_RST) (state_ff.pend && !(cmd_ok && cmd_code == CMD_RESET)) |=> state_ff.pend;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending update dropped without reset"); // [RL2]
  property p_rom_entry;
    @(posedge SYS_CLK) disable iff (SYS_RST) (cmd_ok && cmd_code == CMD_ROM) |=> (ROM_MODE && LOG_SUPPRESS);
  endproperty
  a_rom_entry: assert property (p_rom_entry) else $error("rom command did not enter rom mode"); // [RL3]
  property p_pec_bad;
    @(posedge SYS_CLK) disable iff (SYS_RST) (cmd_take && state_ff.st == S_RUN && !pec_ok) |-> !cmd_ok ##1 state_ff.status[ST_PEC];
  endproperty
  a_pec_bad: assert property (p_pec_bad) else $error("bad pec frame acted on"); // [RL4]
  property p_no_pec;
    @(posedge SYS_CLK) disable iff (SYS_RST) (cmd_take && state_ff.st == S_RUN && cmd_len == LEN_NO_PEC) |-> cmd_ok;
  endproperty
  a_no_pec: assert property (p_no_pec) else $error("frame without pec refused"); // [RL4]
  property p_sum_track;
    @(posedge SYS_CLK) disable iff (SYS_RST) log_we |=> nv_sum_ff == LOG_W'($past(nv_sum_ff) + $past(FAULT_CODE));
  endproperty
  a_sum_track: assert property (p_sum_track) else $error("log checksum not updated"); // [RL6]
  property p_corrupt;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (state_ff.st == S_CHECK && state_ff.cnt >= nv_cnt_ff && state_ff.sum != nv_sum_ff)
      |=> (nv_cnt_ff == '0 && state_ff.status[ST_CORRUPT] && state_ff.st == S_RUN);
  endproperty
  a_corrupt: assert property (p_corrupt) else $error("corrupt log not erased"); // [RL7]
  property p_store;
    @(posedge SYS_CLK) disable iff (SYS_RST) (state_ff.st == S_RUN && fl_we) |-> state_ff.erased;
  endproperty
  a_store: assert property (p_store) else $error("flash written outside store or image path"); // [RL8] [RL1]
  property p_wp;
    @(posedge SYS_CLK) disable iff (SYS_RST) (state_ff.st == S_RUN && state_ff.wp) |-> !fl_we ##1 state_ff.st != S_ERASE;
  endproperty
  a_wp: assert property (p_wp) else $error("flash changed under write protection"); // [RL9]

  c_rom: cover property (@(posedge SYS_CLK) cmd_ok && cmd_code == CMD_ROM);
  c_corrupt: cover property (@(posedge SYS_CLK) nv_clr);
  c_store: cover property (@(posedge SYS_CLK) set_b[ST_STORE]);
  c_image: cover property (@(posedge SYS_CLK) set_b[ST_IMAGE]);
endmodule : cfl_top

// *** verification/cfl_host.sv ***
/*
  Host partner: an AXI4-Lite master that notes each expected answer.
  Assumes one clock; the bench pops the two queues as answers appear.
*/
`timescale 1ns/1ps
module cfl_host (
  input  wire logic        clk,
  output var  logic [7:0]  aw_addr,
  output var  logic        aw_valid,
  input  wire logic        aw_ready,
  output var  logic [31:0] w_data,
  output var  logic        w_valid,
  input  wire logic        w_ready,
  input  wire logic        b_valid,
  output var  logic        b_ready,
  output var  logic [7:0]  ar_addr,
  output var  logic        ar_valid,
  input  wire logic        ar_ready,
  input  wire logic        r_valid,
  output var  logic        r_ready
);
  logic [1:0]  bq[$];
  logic [65:0] rq[$];
  // Idle bus at time zero.
  initial begin
    {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
    {aw_addr, ar_addr, w_data} = '0;
  end
  // Write; the caller orders unprotect, erase, image, reset itself.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bq.push_back(er);
    @(posedge clk);
    aw_addr  <= a;
    w_data   <= d;
    aw_valid <= 1'b1;
    w_valid  <= 1'b1;
    b_ready  <= 1'b1;
    fork
      begin
        do @(posedge clk); while (aw_ready !== 1'b1);
        aw_valid <= 1'b0;
      end
      begin
        do @(posedge clk); while (w_ready !== 1'b1);
        w_valid <= 1'b0;
      end
    join
    do @(posedge clk); while (b_valid !== 1'b1);
    b_ready <= 1'b0;
  endtask : wr
  // Read; only bits under mask m are judged.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    rq.push_back({er, m, e});
    @(posedge clk);
    ar_addr  <= a;
    ar_valid <= 1'b1;
    r_ready  <= 1'b1;
    do @(posedge clk); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    do @(posedge clk); while (r_valid !== 1'b1);
    r_ready <= 1'b0;
  endtask : rd
endmodule : cfl_host

// *** verification/cfl_top_bench.sv ***
/*
  Self-checking bench for cfl_top: live update, store, log guard, ROM entry.
  Assumes the host partner cfl_host and the default depth parameters.
*/
`timescale 1ns/1ps
module cfl_top_bench;
  import cfl_pkg::*;
  logic        clk, rst, fv, irq, rom, sup, busy;
  logic [15:0] fc;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data, w0, w1, v;
  logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_valid, r_ready;
  logic [1:0]  b_resp, r_resp;
  int          err_total = 0;
  int          num_checks = 0;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam logic [1:0] ER = RESP_SLVERR;

  cfl_top dut (.SYS_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
    .FAULT_VALID(fv), .FAULT_CODE(fc), .IRQ(irq), .ROM_MODE(rom), .LOG_SUPPRESS(sup), .CFG_BUSY(busy));
  cfl_host h (.clk(clk), .aw_addr(aw_addr), .aw_valid(aw_valid), .aw_ready(aw_ready),
    .w_data(w_data), .w_valid(w_valid), .w_ready(w_ready), .b_valid(b_valid), .b_ready(b_ready),
    .ar_addr(ar_addr), .ar_valid(ar_valid), .ar_ready(ar_ready), .r_valid(r_valid), .r_ready(r_ready));

  // 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // CRC-8 over the code byte alone, so a flipped bit cannot pass as a command.
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = PEC_INIT ^ b;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ PEC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task automatic cmp_wr(input logic [1:0] r, input logic [1:0] e);
    num_checks++;
    if (r !== e) begin
      err_total++;
      $display("wrong value at %0t: write resp %h", $time, r);
    end
  endtask : cmp_wr
  task automatic cmp_rd(input logic [31:0] d, input logic [1:0] r, input logic [65:0] e);
    num_checks++;
    if (((d & e[63:32]) !== e[31:0]) || (r !== e[65:64])) begin
      err_total++;
      $display("wrong value at %0t: read %h resp %h", $time, d, r);
    end
  endtask : cmp_rd
  // Level outputs are judged at the falling edge, once every update has landed.
  task automatic pin(ref logic g, input logic e);
    @(negedge clk);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: output pin", $time);
    end
  endtask : pin
  task automatic cmd(input logic [7:0] c, input logic [7:0] p, input logic [1:0] l, input logic [1:0] er);
    h.wr(REG_CMD, {14'h0, l, p, c}, er);
  endtask : cmd
  task automatic fault(input logic [15:0] c);
    @(posedge clk);
    fv <= 1'b1;
    fc <= c;
    @(posedge clk);
    fv <= 1'b0;
  endtask : fault
  task automatic idle();
    do @(posedge clk); while (busy !== 1'b0);
  endtask : idle
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Answers are taken off the queues in the order they were noted.
  always @(posedge clk) begin
    if (b_valid === 1'b1 && b_ready === 1'b1) cmp_wr(b_resp, h.bq.pop_front());
    if (r_valid === 1'b1 && r_ready === 1'b1) cmp_rd(r_data, r_resp, h.rq.pop_front());
  end
  // Watchdog: the whole sequence needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
  // Main sequence.
  initial begin
    {rst, fv, fc} = {1'b1, 17'h0};
    w0 = lfsr(32'h0001490b); // Seed 84235.
    w1 = lfsr(w0);
    v = lfsr(w1);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    idle();
    h.rd(REG_STATE, 32'h8, 32'h8, OK);
    cmd(CMD_ERASE, 8'h0, LEN_NO_PEC, ER);
    h.wr(REG_FLASH, w0, ER);
    h.rd(REG_STATUS, 32'h4, 32'h4, OK);
    h.wr(REG_CTRL, 32'h0, OK);
    cmd(CMD_ERASE, 8'h0, LEN_NO_PEC, OK);
    pin(busy, 1'b1);
    idle();
    h.wr(REG_INDEX, 32'h0, OK);
    h.rd(REG_FLASH, '1, ERASED_WORD, OK);
    h.wr(REG_FLASH, w0, OK);
    h.wr(REG_FLASH, w1, OK);
    fault(16'h1);
    h.rd(REG_STATE, 32'hff02, 32'h2, OK);
    pin(sup, 1'b1);
    cmd(CMD_RESET, 8'h0, LEN_NO_PEC, OK);
    idle();
    h.wr(REG_INDEX, 32'h1, OK);
    h.rd(REG_RAM, '1, w1, OK);
    h.rd(REG_STATE, 32'ha, 32'h8, OK);
    h.wr(REG_RAM, v, OK);
    h.rd(REG_FLASH, '1, w1, OK);
    h.wr(REG_CTRL, 32'h0, OK);
    cmd(CMD_STORE, 8'h0, LEN_NO_PEC, OK);
    idle();
    h.rd(REG_FLASH, '1, v, OK);
    cmd(CMD_RESET, 8'h0, LEN_NO_PEC, OK);
    idle();
    h.rd(REG_RAM, '1, v, OK);
    fault(w0[15:0]);
    fault(w0[31:16]);
    h.rd(REG_STATE, 32'hff00, 32'h200, OK);
    h.rd(REG_LOG_SUM, 32'hffff, {16'h0, w0[15:0] + w0[31:16]}, OK);
    h.wr(REG_LOG_SUM, {16'h0, ~(w0[15:0] + w0[31:16])}, OK);
    cmd(CMD_RESET, 8'h0, LEN_NO_PEC, OK);
    idle();
    h.rd(REG_STATE, 32'hff00, 32'h0, OK);
    h.rd(REG_LOG_SUM, 32'hffff, 32'h0, OK);
    h.wr(REG_MASK, 32'h8, OK);
    pin(irq, 1'b1);
    h.wr(REG_STATUS, 32'h8, OK);
    pin(irq, 1'b0);
    cmd(CMD_ROM, crc8(CMD_ROM) ^ 8'h1, LEN_PEC, OK);
    pin(rom, 1'b0);
    h.rd(REG_STATUS, 32'h2, 32'h2, OK);
    cmd(CMD_ROM, crc8(CMD_ROM), LEN_PEC, OK);
    pin(rom, 1'b1);
    cmd(CMD_STORE, 8'h0, LEN_NO_PEC, ER);
    h.wr(REG_CTRL, 32'h3, OK);
    pin(rom, 1'b0);
    cmd(CMD_ROM, 8'h0, LEN_NO_PEC, OK);
    pin(rom, 1'b1);
    h.wr(REG_CTRL, 32'h3, OK);
    // A pin reset keeps the log, so one fresh entry must still be counted after the check.
    fault(w1[15:0]);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pin(busy, 1'b1);
    idle();
    h.rd(REG_STATE, 32'hff09, 32'h108, OK);
    h.rd(8'h40, '1, 32'h0, ER);
    summarize();
  end
endmodule : cfl_top_bench
